/* inc/iafs_pkg.sv */
// package of constants for the indirect access function select block
`default_nettype none
package iafs_pkg;
    // ------------------------------------------------------------
    // control register 0 field layout
    // ------------------------------------------------------------
    localparam int ADDR_HI_LSB = 0;   // indirect address [9:8]
    localparam int ADDR_HI_MSB = 1;
    localparam int TSEL_LSB = 2;      // table select / address [11:10]
    localparam int TSEL_MSB = 3;
    localparam int DIR_BIT = 4;       // read high, write low
    localparam int FSEL_LSB = 5;      // function select
    localparam int FSEL_MSB = 7;
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;

    // ------------------------------------------------------------
    // launched operation outputs after reset
    // ------------------------------------------------------------
    localparam logic OP_START_RESET = 1'h0;
    localparam logic OP_READ_RESET = 1'h0;     // write direction
    localparam logic [1:0] OP_TSEL_RESET = 2'h0;
    localparam logic OP_TMODE_RESET = 1'h1;    // table mode
    localparam logic [11:0] OP_ADDR_RESET = 12'h000;

    // ------------------------------------------------------------
    // function select codes
    // ------------------------------------------------------------
    localparam logic [2:0] FSEL_TABLE = 3'h0;
    localparam logic [2:0] FSEL_EEE = 3'h1;
    localparam logic [2:0] FSEL_FILTER = 3'h2;
    localparam logic [2:0] FSEL_RSVD = 3'h3;
    localparam logic [2:0] FSEL_WAKE = 3'h4;
    localparam logic [2:0] FSEL_CABLE = 3'h5;

    // ------------------------------------------------------------
    // target one-hot encoding
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        IAFS_TGT_NONE = 6'h00,
        IAFS_TGT_TABLE = 6'h01,
        IAFS_TGT_EEE = 6'h02,
        IAFS_TGT_FILTER = 6'h04,
        IAFS_TGT_WAKE = 6'h08,
        IAFS_TGT_CABLE = 6'h10,
        IAFS_TGT_RSVD = 6'h20
    } iafs_target_t;

    // table select codes in table mode
    localparam logic [1:0] TBL_STATIC = 2'h0;
    localparam logic [1:0] TBL_VLAN = 2'h1;
    localparam logic [1:0] TBL_DYNAMIC = 2'h2;
    localparam logic [1:0] TBL_MIB = 2'h3;
endpackage
`default_nettype wire

/* src/iafs_decode.sv */
// combinational decode of function select into target and address
`timescale 1ns/100ps
`default_nettype none
module iafs_decode (
    // control register fields
    input wire logic [7:0] ctrl0,
    input wire logic [7:0] ctrl1,
    // decoded view
    output iafs_pkg::iafs_target_t target,
    output logic [1:0] table_sel,
    output logic table_mode,
    output logic [11:0] ind_addr
);
    logic [2:0] fsel;
    assign fsel = ctrl0[iafs_pkg::FSEL_MSB:iafs_pkg::FSEL_LSB];

    // bits [3:2] pick a table only in table mode
    always_comb begin
        table_mode = (fsel == iafs_pkg::FSEL_TABLE);
        if (table_mode) begin
            table_sel = ctrl0[iafs_pkg::TSEL_MSB:iafs_pkg::TSEL_LSB];
            ind_addr = {2'h0,
                ctrl0[iafs_pkg::ADDR_HI_MSB:iafs_pkg::ADDR_HI_LSB], ctrl1};
        end else begin
            table_sel = 2'h0;
            // bits [3:2] become address msbs; [11:8] port, [7:0] pointer
            ind_addr = {ctrl0[iafs_pkg::TSEL_MSB:iafs_pkg::ADDR_HI_LSB],
                ctrl1};
        end
    end

    // function select to target
    always_comb begin
        unique case (fsel)
            iafs_pkg::FSEL_TABLE: target = iafs_pkg::IAFS_TGT_TABLE;
            iafs_pkg::FSEL_EEE: target = iafs_pkg::IAFS_TGT_EEE;
            iafs_pkg::FSEL_FILTER: target = iafs_pkg::IAFS_TGT_FILTER;
            iafs_pkg::FSEL_RSVD: target = iafs_pkg::IAFS_TGT_RSVD;
            iafs_pkg::FSEL_WAKE: target = iafs_pkg::IAFS_TGT_WAKE;
            iafs_pkg::FSEL_CABLE: target = iafs_pkg::IAFS_TGT_CABLE;
            default: target = iafs_pkg::IAFS_TGT_NONE;
        endcase
    end
endmodule
`default_nettype wire

/* src/iafs_ctrl.sv */
// indirect access control register bank with function select decode
// Function
// - function zero: bits 3:2 select table
// - nonzero function: bits 3:2 are address msbs
// - function one: energy registers, port and pointer
// - function two: filter rules, port and pointer
// - function four wake-up; three reserved, unwritten
// - function five: cable diagnosis path
// - write of low address launches operation
// - bit four: one read, zero write
`timescale 1ns/100ps
`default_nettype none
module iafs_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host register writes (same clock domain)
    input wire logic ctrl0_wr,
    input wire logic ctrl1_wr,
    input wire logic [7:0] wr_data,
    // register readback
    output logic [7:0] ctrl0,
    output logic [7:0] ctrl1,
    // launched operation
    output logic op_start,
    output logic op_read,
    output iafs_pkg::iafs_target_t op_target,
    output logic [1:0] op_table_sel,
    output logic op_table_mode,
    output logic [11:0] op_addr,
    // live decode
    output iafs_pkg::iafs_target_t cur_target
);
    // ------------------------------------------------------------
    // field helpers
    // ------------------------------------------------------------
    // function select field of a control register 0 byte
    function automatic logic [2:0] fsel_of(input logic [7:0] c);
        return c[iafs_pkg::FSEL_MSB:iafs_pkg::FSEL_LSB];
    endfunction

    // direction bit of a control register 0 byte, high for read
    function automatic logic dir_of(input logic [7:0] c);
        return c[iafs_pkg::DIR_BIT];
    endfunction

    // table select or address [11:10] field
    function automatic logic [1:0] tsel_of(input logic [7:0] c);
        return c[iafs_pkg::TSEL_MSB:iafs_pkg::TSEL_LSB];
    endfunction

    // address [9:8] field
    function automatic logic [1:0] addr_hi_of(input logic [7:0] c);
        return c[iafs_pkg::ADDR_HI_MSB:iafs_pkg::ADDR_HI_LSB];
    endfunction

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [2:0] func_sel;
    logic dir_read;
    logic [1:0] tsel_addr;
    logic [1:0] addr_hi;
    logic [7:0] next_ctrl0;
    logic [7:0] next_ctrl1;
    iafs_pkg::iafs_target_t dec_target;
    logic [1:0] dec_table_sel;
    logic dec_table_mode;
    logic [11:0] dec_addr;
    iafs_pkg::iafs_target_t live_target;

    // function select field, zero after reset selects table mode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            func_sel <= fsel_of(iafs_pkg::CTRL0_RESET);
        end else if (ctrl0_wr) begin
            func_sel <= fsel_of(wr_data);
        end
    end

    // direction bit, zero after reset means write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dir_read <= dir_of(iafs_pkg::CTRL0_RESET);
        end else if (ctrl0_wr) begin
            dir_read <= dir_of(wr_data);
        end
    end

    // table select or address [11:10] field
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tsel_addr <= tsel_of(iafs_pkg::CTRL0_RESET);
        end else if (ctrl0_wr) begin
            tsel_addr <= tsel_of(wr_data);
        end
    end

    // address [9:8] field
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_hi <= addr_hi_of(iafs_pkg::CTRL0_RESET);
        end else if (ctrl0_wr) begin
            addr_hi <= addr_hi_of(wr_data);
        end
    end

    // control register 1 holds address low byte
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl1 <= iafs_pkg::CTRL1_RESET;
        end else if (ctrl1_wr) begin
            ctrl1 <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // register readback
    // ------------------------------------------------------------
    // fields packed back at their register positions
    always_comb begin
        ctrl0[iafs_pkg::FSEL_MSB:iafs_pkg::FSEL_LSB] = func_sel;
        ctrl0[iafs_pkg::DIR_BIT] = dir_read;
        ctrl0[iafs_pkg::TSEL_MSB:iafs_pkg::TSEL_LSB] = tsel_addr;
        ctrl0[iafs_pkg::ADDR_HI_MSB:iafs_pkg::ADDR_HI_LSB] = addr_hi;
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // decode sees the byte being written so the launch uses it
    assign next_ctrl1 = ctrl1_wr ? wr_data : ctrl1;

    // decode of the values an operation launches with
    iafs_decode u_decode (
        .ctrl0(ctrl0),
        .ctrl1(next_ctrl1),
        .target(dec_target),
        .table_sel(dec_table_sel),
        .table_mode(dec_table_mode),
        .ind_addr(dec_addr)
    );

    // live decode follows the value control register 0 is taking
    assign next_ctrl0 = ctrl0_wr ? wr_data : ctrl0;

    // second decode, only its target is used
    iafs_decode u_live (
        .ctrl0(next_ctrl0),
        .ctrl1(ctrl1),
        .target(live_target),
        .table_sel(),
        .table_mode(),
        .ind_addr()
    );

    // live target held in a flop, table after reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cur_target <= iafs_pkg::IAFS_TGT_TABLE;
        end else begin
            cur_target <= live_target;
        end
    end

    // ------------------------------------------------------------
    // operation launch
    // ------------------------------------------------------------
    // one-cycle start pulse after the low address write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_start <= iafs_pkg::OP_START_RESET;
        end else begin
            op_start <= ctrl1_wr;
        end
    end

    // direction of the launched operation, from bit four
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_read <= iafs_pkg::OP_READ_RESET;
        end else if (ctrl1_wr) begin
            op_read <= dir_of(ctrl0);
        end
    end

    // target captured at the launching write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_target <= iafs_pkg::IAFS_TGT_TABLE;
        end else if (ctrl1_wr) begin
            op_target <= dec_target;
        end
    end

    // table select captured at the launching write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_table_sel <= iafs_pkg::OP_TSEL_RESET;
        end else if (ctrl1_wr) begin
            op_table_sel <= dec_table_sel;
        end
    end

    // table mode flag captured at the launching write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_table_mode <= iafs_pkg::OP_TMODE_RESET;
        end else if (ctrl1_wr) begin
            op_table_mode <= dec_table_mode;
        end
    end

    // indirect address captured at the launching write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_addr <= iafs_pkg::OP_ADDR_RESET;
        end else if (ctrl1_wr) begin
            op_addr <= dec_addr;
        end
    end
endmodule
`default_nettype wire

/* test/iafs_ctrl_props.sv */
// checker for the indirect access control register bank
`timescale 1ns/100ps
`default_nettype none
module iafs_ctrl_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register writes
    input wire logic ctrl0_wr,
    input wire logic ctrl1_wr,
    input wire logic [7:0] wr_data,
    // register readback
    input wire logic [7:0] ctrl0,
    input wire logic [7:0] ctrl1,
    // launched operation
    input wire logic op_start,
    input wire logic op_read,
    input wire iafs_pkg::iafs_target_t op_target,
    input wire logic [1:0] op_table_sel,
    input wire logic op_table_mode,
    input wire logic [11:0] op_addr,
    // live decode
    input wire iafs_pkg::iafs_target_t cur_target
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire [2:0] fn = ctrl0[7:5]; // function field in use at launch
    a_start_pulse: assert property (
        ctrl1_wr |=> op_start) else $error("launch missed");
    a_start_only: assert property (
        !ctrl1_wr |=> !op_start && $stable(op_addr))
        else $error("launch without trigger");
    a_dir_kept: assert property (
        ctrl1_wr |=> op_read == $past(ctrl0[4])) else $error("bad dir");
    a_table_mode: assert property (ctrl1_wr && fn == 3'h0 |=>
        op_table_mode && op_table_sel == $past(ctrl0[3:2]) &&
        op_addr == {2'h0, $past(ctrl0[1:0]), $past(wr_data)})
        else $error("bad table mode");
    a_addr_msb: assert property (ctrl1_wr && fn != 3'h0 |=>
        !op_table_mode && op_addr == {$past(ctrl0[3:0]), $past(wr_data)})
        else $error("bad address");
    a_eee_target: assert property (ctrl1_wr && fn == 3'h1 |=>
        op_target == iafs_pkg::IAFS_TGT_EEE) else $error("bad eee");
    a_filter_target: assert property (ctrl1_wr && fn == 3'h2 |=>
        op_target == iafs_pkg::IAFS_TGT_FILTER) else $error("bad filter");
    a_wake_target: assert property (ctrl1_wr && fn == 3'h4 |=>
        op_target == iafs_pkg::IAFS_TGT_WAKE) else $error("bad wake");
    a_cable_target: assert property (ctrl1_wr && fn == 3'h5 |=>
        op_target == iafs_pkg::IAFS_TGT_CABLE) else $error("bad cable");
    a_reset_state: assert property ($fell(rst) |->
        ctrl0 == 8'h00 && cur_target == iafs_pkg::IAFS_TGT_TABLE)
        else $error("bad reset state");
endmodule
bind iafs_ctrl iafs_ctrl_chk u_chk (.ref_clk, .rst, .ctrl0_wr, .ctrl1_wr,
    .op_start, .op_read, .op_table_mode, .wr_data, .ctrl0, .ctrl1,
    .op_table_sel, .op_addr, .op_target, .cur_target);
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the indirect access control register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic ref_clk = 0, rst = 1, ctrl0_wr = 0, ctrl1_wr = 0;
    logic op_start, op_read, op_table_mode;
    logic [7:0] wr_data = 8'h00, ctrl0, ctrl1, c0, c1;
    logic [1:0] op_table_sel;
    logic [11:0] op_addr;
    iafs_pkg::iafs_target_t op_target, cur_target;
    int n_fail = 0, checks_done = 0, cyc = 0;
    // function codes per pass; the reserved code is never written
    logic [2:0] fs [10] = '{0, 0, 0, 0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h1, 3'h7};
    logic [5:0] tg [8] = '{6'h01, 6'h02, 6'h04, 6'h20, 6'h08, 6'h10, 6'h00,
        6'h00};
    iafs_ctrl dut (.ref_clk, .rst, .ctrl0_wr, .ctrl1_wr, .wr_data, .ctrl0,
        .ctrl1, .op_start, .op_read, .op_target, .op_table_sel,
        .op_table_mode, .op_addr, .cur_target);
    // clock and hang guard
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 200) begin
            n_fail++;
            end_sim;
        end
    end
    task end_sim;
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [11:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one register write cycle, strobes left for the next call
    task wr(input logic w0, w1, input logic [7:0] d);
        ctrl0_wr = w0;
        ctrl1_wr = w1;
        wr_data = d;
        @(posedge ref_clk);
        #1;
    endtask
    // reset, then eleven launches: table codes 0 to 3, then functions 1, 2, 4, 5, 1 and 7, then both registers written in one cycle
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 rst = 0;
        chk("ctrl0", 0, ctrl0);
        chk("cur_target", 1, cur_target);
        chk("op_read", 0, op_read);
        chk("op_start", 0, op_start);
        for (logic [3:0] i = 0; i < 10; i++) begin
            c0 = {fs[i], i[0], i[1:0], ~i[1:0]};
            c1 = 8'h5a ^ {4'h0, i};
            wr(1, 0, c0);
            chk("cur_target", tg[fs[i]], cur_target);
            chk("ctrl0", c0, ctrl0);
            wr(0, 1, c1);
            chk("op_start", 1, op_start);
            chk("op_read", c0[4], op_read);
            chk("op_target", tg[fs[i]], op_target);
            chk("op_table_mode", fs[i] == 0, op_table_mode);
            chk("op_table_sel",
                fs[i] == 0 ? c0[3:2] : 2'h0, op_table_sel);
            chk("op_addr",
                fs[i] == 0 ? {2'h0, c0[1:0], c1} : {c0[3:0], c1}, op_addr);
            wr(0, 0, 8'h00);
            chk("op_start", 0, op_start);
            chk("ctrl1", c1, ctrl1);
        end
        wr(1, 1, 8'h33);
        chk("op_addr", {c0[3:0], 8'h33}, op_addr);
        chk("op_read", c0[4], op_read);
        chk("ctrl0", 8'h33, ctrl0);
        end_sim;
    end
endmodule
`default_nettype wire
